// >>> hdl/awf_pkg.sv
// constants shared by the avionics word formatter
package awf_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] ADDR_CFG   = 8'h00;
  localparam logic [7:0] ADDR_DATA  = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_PUSH  = 8'h0c;
  localparam logic [7:0] ADDR_STAT  = 8'h10;
  localparam logic [7:0] ADDR_RX    = 8'h14;
  localparam logic [31:0] CFG_RST   = 32'h0000_0000;
  localparam logic [31:0] DATA_RST  = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
  // ****************************************
  // word kinds
  // ****************************************
  localparam logic [3:0] K_BNR  = 4'h0;
  localparam logic [3:0] K_ILS  = 4'h1;
  localparam logic [3:0] K_DME  = 4'h2;
  localparam logic [3:0] K_UTC  = 4'h3;
  localparam logic [3:0] K_RH   = 4'h4;
  localparam logic [3:0] K_DATE = 4'h5;
  localparam logic [3:0] K_FLT  = 4'h6;
  localparam logic [3:0] K_ALT  = 4'h7;
  localparam logic [3:0] K_TCAS = 4'h8;
  // ****************************************
  // fixed labels (octal 202 150 164 260 206)
  // ****************************************
  localparam logic [7:0] LBL_DME  = 8'h82;
  localparam logic [7:0] LBL_UTC  = 8'h68;
  localparam logic [7:0] LBL_RH   = 8'h74;
  localparam logic [7:0] LBL_DATE = 8'hb0;
  localparam logic [7:0] LBL_ALT  = 8'h86;
  // ****************************************
  // sign_status_field codes for binary_numeric_format
  // ****************************************
  localparam logic [1:0] SSM_FW  = 2'h0;
  localparam logic [1:0] SSM_NCD = 2'h1;
  localparam logic [1:0] SSM_FT  = 2'h2;
  localparam logic [1:0] SSM_NO  = 2'h3;
  // ****************************************
  // limits and sizes
  // ****************************************
  localparam logic [4:0]  UTC_HR_MAX = 5'h18;
  localparam logic [5:0]  UTC_MS_MAX = 6'h3c;
  localparam logic [15:0] TCAS_MAX   = 16'h07ff;
  localparam logic [13:0] FLT_MAX    = 14'h270f;
  localparam int          FIFO_DEPTH = 8;
  localparam int          STAT_ERR   = 8;
endpackage

// >>> hdl/awf_top.sv
// avionics word formatter: apb registers, word packing, tx fifo, rx check
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps

module awf_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // fill side
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [W-1:0]           in_data,
  // drain side
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [W-1:0]                out_data,
  // fill level
  output logic [$clog2(D+1)-1:0]      count
);
  localparam int AW = $clog2(D);
  localparam logic [$clog2(D+1)-1:0] FULL = ($clog2(D+1))'(D);
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic          wr;
  logic          rd;

  assign in_ready  = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data  = mem_q[rp_q];
  assign wr        = in_valid && in_ready;
  assign rd        = out_valid && out_ready;

  always_ff @(posedge pclk) begin
    if (wr) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      count <= '0;
    end else begin
      if (wr) begin
        wp_q <= (wp_q == LAST) ? '0 : wp_q + 1'b1;
      end
      if (rd) begin
        rp_q <= (rp_q == LAST) ? '0 : rp_q + 1'b1;
      end
      if (wr && !rd) begin
        count <= count + 1'b1;
      end else if (rd && !wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // awf_fifo

module awf_top #(
  parameter int DEPTH = awf_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // transmit word stream
  output logic [31:0]      tx_word,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  // received word check, same clock
  input  wire logic [31:0] rx_word,
  input  wire logic        rx_valid
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [18:0] twos(input logic neg, input logic [18:0] m);
    twos = neg ? (~m + 19'h00001) : m;
  endfunction

  function automatic logic [7:0] bcd2(input logic [6:0] v);
    bcd2 = {4'(v / 7'd10), 4'(v % 7'd10)};
  endfunction

  function automatic logic [15:0] bcd4(input logic [13:0] v);
    bcd4 = {4'(v / 14'd1000), 4'((v / 14'd100) % 14'd10),
            4'((v / 14'd10) % 14'd10), 4'(v % 14'd10)};
  endfunction

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] cfg_q;
  logic [31:0] data_q;
  logic [31:0] flags_q;
  logic [31:0] rx_last_q;
  logic [15:0] rx_cnt_q;
  logic        err_q;
  logic [31:0] prdata_q;
  logic        acc;
  logic        wen;
  logic        push;
  logic        push_ready;
  logic        mapped;
  logic [$clog2(DEPTH+1)-1:0] level;
  logic [31:0] fmt_w;
  logic [31:0] stat_w;

  assign acc    = psel && penable;
  assign push   = acc && pwrite && (paddr == awf_pkg::ADDR_PUSH);
  // a full fifo holds the push write in its access phase
  assign pready = !(push && !push_ready);
  assign wen    = acc && pwrite && pready;
  assign mapped = (paddr == awf_pkg::ADDR_CFG) || (paddr == awf_pkg::ADDR_DATA) ||
                  (paddr == awf_pkg::ADDR_FLAGS) || (paddr == awf_pkg::ADDR_PUSH) ||
                  (paddr == awf_pkg::ADDR_STAT) || (paddr == awf_pkg::ADDR_RX);
  assign pslverr = acc && !mapped;
  assign prdata  = prdata_q;
  assign stat_w  = {rx_cnt_q, 7'h00, err_q, 2'h0, (level == '0), !push_ready,
                    4'(level)};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q   <= awf_pkg::CFG_RST;
      data_q  <= awf_pkg::DATA_RST;
      flags_q <= awf_pkg::FLAGS_RST;
    end else if (wen) begin
      if (paddr == awf_pkg::ADDR_CFG) begin
        cfg_q <= pwdata;
      end else if (paddr == awf_pkg::ADDR_DATA) begin
        data_q <= pwdata;
      end else if (paddr == awf_pkg::ADDR_FLAGS) begin
        flags_q <= pwdata;
      end
    end
  end

  // read data is taken in the setup cycle so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      if (paddr == awf_pkg::ADDR_CFG) begin
        prdata_q <= cfg_q;
      end else if (paddr == awf_pkg::ADDR_DATA) begin
        prdata_q <= data_q;
      end else if (paddr == awf_pkg::ADDR_FLAGS) begin
        prdata_q <= flags_q;
      end else if (paddr == awf_pkg::ADDR_STAT) begin
        prdata_q <= stat_w;
      end else if (paddr == awf_pkg::ADDR_RX) begin
        prdata_q <= rx_last_q;
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // word packing
  // ****************************************
  always_comb begin
    logic [18:0] sv;
    logic [4:0]  hr;
    logic [5:0]  mn;
    logic [5:0]  sc;
    logic [15:0] rg;
    logic [13:0] fn;
    logic [7:0]  dm;
    logic [7:0]  mo;
    logic [1:0]  sign_status_field;
    sv  = twos(data_q[31], data_q[18:0]);
    hr  = (data_q[16:12] > awf_pkg::UTC_HR_MAX) ? awf_pkg::UTC_HR_MAX : data_q[16:12];
    mn  = (data_q[11:6] > awf_pkg::UTC_MS_MAX) ? awf_pkg::UTC_MS_MAX : data_q[11:6];
    sc  = (data_q[5:0] > awf_pkg::UTC_MS_MAX) ? awf_pkg::UTC_MS_MAX : data_q[5:0];
    rg  = (data_q[15:0] > awf_pkg::TCAS_MAX) ? awf_pkg::TCAS_MAX : data_q[15:0];
    fn  = (data_q[13:0] > awf_pkg::FLT_MAX) ? awf_pkg::FLT_MAX : data_q[13:0];
    dm  = bcd2({2'h0, data_q[4:0]});
    mo  = bcd2({3'h0, data_q[8:5]});
    sign_status_field = cfg_q[12:11];
    fmt_w = 32'h0000_0000;
    fmt_w[7:0] = cfg_q[7:0];
    if (cfg_q[10]) begin
      fmt_w[9:8] = cfg_q[9:8];
    end
    case (cfg_q[16:13])
      awf_pkg::K_ILS: begin
        fmt_w[28:11] = {sv[18], sv[16:0]};
        fmt_w[10]    = flags_q[0];
      end
      awf_pkg::K_DME: begin
        fmt_w[7:0]   = awf_pkg::LBL_DME;
        fmt_w[28:12] = data_q[16:0];
        fmt_w[10]    = flags_q[1];
        fmt_w[11]    = flags_q[2] && flags_q[3];
      end
      awf_pkg::K_UTC: begin
        fmt_w[7:0]   = awf_pkg::LBL_UTC;
        fmt_w[28:12] = {hr, mn, sc};
        fmt_w[10]    = flags_q[4];
      end
      awf_pkg::K_RH: begin
        fmt_w[7:0]   = awf_pkg::LBL_RH;
        fmt_w[28:11] = {sv[18], sv[16:0]};
        fmt_w[10]    = flags_q[5];
      end
      awf_pkg::K_DATE: begin
        fmt_w[7:0]   = awf_pkg::LBL_DATE;
        fmt_w[28:12] = {dm[5:0], mo[4:0], data_q[14:9]};
      end
      awf_pkg::K_FLT: begin
        fmt_w[28:13] = bcd4(fn);
      end
      awf_pkg::K_ALT: begin
        fmt_w[7:0]   = awf_pkg::LBL_ALT;
        fmt_w[28:13] = data_q[15:0];
        fmt_w[12:10] = data_q[18:16];
        sign_status_field          = awf_pkg::SSM_FW;
      end
      awf_pkg::K_TCAS: begin
        fmt_w[28:18] = rg[10:0];
      end
      default: begin
        fmt_w[28:10] = sv;
        for (int i = 0; i < 7; i++) begin
          if (i < int'(cfg_q[19:17])) begin
            fmt_w[10+i] = flags_q[8+i];
          end
        end
      end
    endcase
    fmt_w[30:29] = sign_status_field;
    fmt_w[31]    = ~^fmt_w[30:0];
  end

  awf_fifo #(
    .W (32),
    .D (DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (push),
    .in_ready  (push_ready),
    .in_data   (fmt_w),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_word),
    .count     (level)
  );

  // ****************************************
  // receive check
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_last_q <= 32'h0000_0000;
      rx_cnt_q  <= 16'h0000;
    end else if (rx_valid) begin
      rx_last_q <= rx_word;
      rx_cnt_q  <= rx_cnt_q + 16'h0001;
    end
  end

  // a corrupt word arriving with the clear still sets the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (rx_valid && !(^rx_word)) begin
      err_q <= 1'b1;
    end else if (wen && (paddr == awf_pkg::ADDR_STAT) && pwdata[awf_pkg::STAT_ERR]) begin
      err_q <= 1'b0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence push_s;
    push && push_ready;
  endsequence

  sequence bad_rx_s;
    rx_valid && !(^rx_word);
  endsequence

  parity_odd_a: assert property (tx_valid |-> ^tx_word)
    else $error("tx word parity not odd");
  rx_error_a: assert property (bad_rx_s |=> err_q)
    else $error("even parity word not flagged");
  push_out_a: assert property (push_s |=> tx_valid)
    else $error("pushed word not offered");
  // judged from the fill level, not from the fifo's own ready
  stall_full_a: assert property (push && level == ($clog2(DEPTH+1))'(DEPTH) |-> !pready)
    else $error("push not stalled when full");
  ils_inhibit_a: assert property ((push_s and (cfg_q[16:13] == awf_pkg::K_ILS))
      |-> fmt_w[10] == flags_q[0])
    else $error("tune inhibit bit wrong");
  dme_bits_a: assert property ((push_s and (cfg_q[16:13] == awf_pkg::K_DME))
      |-> fmt_w[11:10] == {flags_q[2] && flags_q[3], flags_q[1]})
    else $error("distance flags wrong");
  utc_range_a: assert property ((push_s and (cfg_q[16:13] == awf_pkg::K_UTC))
      |-> fmt_w[28:24] <= 5'h18 && fmt_w[23:18] <= 6'h3c && fmt_w[17:12] <= 6'h3c
      && fmt_w[10] == flags_q[4])
    else $error("time word out of range");
  alt_status_a: assert property ((push_s and (cfg_q[16:13] == awf_pkg::K_ALT))
      |-> fmt_w[30:29] == 2'h0 && fmt_w[7:0] == 8'h86)
    else $error("altitude status not 00");
  sdi_zero_a: assert property ((push_s and !cfg_q[10]) |-> fmt_w[9:8] == 2'h0)
    else $error("unused identifier not zero");
  tcas_max_a: assert property ((push_s and (cfg_q[16:13] == awf_pkg::K_TCAS))
      |-> fmt_w[28:18] == ((data_q[15:11] != 5'h00) ? 11'h7ff : data_q[10:0])
      && fmt_w[17:10] == 8'h00)
    else $error("intruder range too large");
endmodule // awf_top

// >>> verification/awf_rx_model.sv
// receiving unit model on the far side of the word stream
`timescale 1ns/1ps
module awf_rx_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // word stream
  input  wire logic [31:0] tx_word,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  // loop back into the receive check
  output logic [31:0]      rx_word,
  output logic             rx_valid,
  // bench controls and status
  input  wire logic        stall,
  input  wire logic        slow,
  input  wire logic        flip,
  output int               n_bad,
  output logic             test_ok
);
  logic [31:0] got[$];
  logic        phase_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      phase_q  <= 1'b0;
      rx_valid <= 1'b0;
      rx_word  <= 32'h0;
      n_bad    <= 0;
      test_ok  <= 1'b1;
    end else begin
      phase_q  <= ~phase_q;
      tx_ready <= !stall && (!slow || phase_q);
      rx_valid <= 1'b0;
      // idle line inverts so a stale word never reads as fresh
      rx_word  <= ~rx_word;
      if (tx_valid && tx_ready) begin
        got.push_back(tx_word);
        rx_valid <= 1'b1;
        // flip corrupts only the looped copy, never the checked one
        rx_word  <= tx_word ^ {flip, 31'h0};
        if (^tx_word !== 1'b1) n_bad <= n_bad + 1;
        if (tx_word[7:0] == awf_pkg::LBL_RH) test_ok <= !tx_word[10];
      end
    end
  end
endmodule // awf_rx_model

// >>> verification/test_avionics_word_formatter.sv
// self-checking bench for the avionics word formatter
`timescale 1ns/1ps
module test_avionics_word_formatter;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, tx_word, rx_word, rd, lastw, c;
  logic        pready, pslverr, tx_valid, tx_ready, rx_valid, err, test_ok;
  logic        stall = 0, slow = 0, flip = 0;
  int          n_mismatch = 0, num_checks = 0, n_bad, cyc = 0;
  always #5 pclk = ~pclk;
  awf_top #(.DEPTH(8)) awf_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tx_word, .tx_valid, .tx_ready, .rx_word, .rx_valid);
  awf_rx_model awf_rx_model_inst (.pclk, .presetn, .tx_word, .tx_valid, .tx_ready,
    .rx_word, .rx_valid, .stall, .slow, .flip, .n_bad, .test_ok);
  // ****
  // tasks
  // ****
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] mk(input logic [3:0] k, input logic [7:0] l,
    input logic [1:0] s, input logic e, input logic [1:0] sd, input logic [2:0] n);
    return {12'h0, n, k, s, e, sd, l};
  endfunction
  function automatic int lim(input int v, input int m);
    return v > m ? m : v;
  endfunction
  function automatic logic [15:0] bcd(input int v);
    return {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction
  function automatic logic [31:0] expw(input logic [31:0] c, d, f);
    logic [31:0] w;
    logic [18:0] v;
    w = {1'b0, c[12:11], 19'h0, c[10] ? c[9:8] : 2'h0, c[7:0]};
    v = d[31] ? -d[18:0] : d[18:0];
    case (c[16:13])
      default: begin
        for (int i = 0; i < int'(c[19:17]); i++) v[i] = f[8+i];
        w[28:10] = v;
      end
      awf_pkg::K_ILS: w[28:10] = {v[18], v[16:0], f[0]};
      awf_pkg::K_DME: w[28:0] = {d[16:0], f[2] & f[3], f[1], w[9:8], awf_pkg::LBL_DME};
      awf_pkg::K_UTC: w[28:0] = {5'(lim(d[16:12], 24)), 6'(lim(d[11:6], 60)),
        6'(lim(d[5:0], 60)), 1'b0, f[4], w[9:8], awf_pkg::LBL_UTC};
      awf_pkg::K_RH: w[28:0] = {v[18], v[16:0], f[5], w[9:8], awf_pkg::LBL_RH};
      awf_pkg::K_DATE: w[28:0] = {6'(bcd(d[4:0])), 5'(bcd(d[8:5])), d[14:9], 2'h0,
        w[9:8], awf_pkg::LBL_DATE};
      awf_pkg::K_FLT: w[28:13] = bcd(lim(d[13:0], 9999));
      awf_pkg::K_ALT: w[30:0] = {2'h0, d[15:0], d[18:16], w[9:8], awf_pkg::LBL_ALT};
      awf_pkg::K_TCAS: w[28:18] = 11'(lim(d[15:0], 2047));
    endcase
    w[31] = ~^w[30:0];
    return w;
  endfunction
  task automatic push(input logic [31:0] c, d, f);
    apb(1'b1, awf_pkg::ADDR_CFG, c);
    apb(1'b1, awf_pkg::ADDR_DATA, d);
    apb(1'b1, awf_pkg::ADDR_FLAGS, f);
    apb(1'b1, awf_pkg::ADDR_PUSH, 32'h0);
  endtask
  task automatic take(input logic [31:0] exp, input int n);
    int t = 0;
    while (awf_rx_model_inst.got.size() < n && t < 300) begin
      @(posedge pclk);
      t++;
    end
    lastw = exp;
    // a word that never arrived counts against the run
    if (awf_rx_model_inst.got.size() < n) n_mismatch++;
    if (awf_rx_model_inst.got.size() == 0) check(32'h0, exp);
    else check(awf_rx_model_inst.got.pop_front(), exp);
  endtask
  task automatic row(input logic [3:0] k, input logic [7:0] l, input logic [1:0] s,
    input logic e, input logic [1:0] sd, input logic [2:0] n, input logic [31:0] d, f);
    c = mk(k, l, s, e, sd, n);
    push(c, d, f);
    take(expw(c, d, f), 1);
  endtask
  // ****
  // tests
  // ****
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, awf_pkg::ADDR_CFG, 32'h0);
    check(rd, awf_pkg::CFG_RST);
    apb(1'b0, awf_pkg::ADDR_FLAGS, 32'h0);
    check(rd, awf_pkg::FLAGS_RST);
    apb(1'b0, awf_pkg::ADDR_STAT, 32'h0);
    check(rd, 32'h20);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    row(4'h0, 8'h5a, 2'h0, 1'b1, 2'h2, 3'h2, 32'h80000005, 32'h100);
    row(4'h0, 8'h33, 2'h1, 1'b0, 2'h3, 3'h0, 32'h41234, 32'h7f00);
    row(4'h1, 8'h7b, 2'h2, 1'b0, 2'h0, 3'h0, 32'h12345, 32'h1);
    row(4'h1, 8'h7b, 2'h3, 1'b1, 2'h1, 3'h0, 32'h12345, 32'h3e);
    row(4'h2, 8'h00, 2'h3, 1'b0, 2'h0, 3'h0, 32'h15555, 32'he);
    row(4'h2, 8'h00, 2'h3, 1'b0, 2'h0, 3'h0, 32'h15555, 32'h8);
    row(4'h3, 8'h00, 2'h3, 1'b0, 2'h0, 3'h0, 32'h1fffb, 32'h10);
    row(4'h3, 8'h00, 2'h3, 1'b0, 2'h0, 3'h0, 32'h1703c, 32'h0);
    row(4'h4, 8'h00, 2'h3, 1'b0, 2'h0, 3'h0, 32'h20001, 32'h20);
    row(4'h5, 8'h00, 2'h3, 1'b0, 2'h0, 3'h0, 32'h6517, 32'h0);
    row(4'h6, 8'h21, 2'h3, 1'b0, 2'h0, 3'h0, 32'h6b4, 32'h0);
    row(4'h6, 8'h21, 2'h3, 1'b0, 2'h0, 3'h0, 32'h3039, 32'h0);
    row(4'h7, 8'h00, 2'h3, 1'b0, 2'h0, 3'h0, 32'h5abcd, 32'h0);
    row(4'h8, 8'h44, 2'h3, 1'b0, 2'h0, 3'h0, 32'hbb8, 32'h0);
    row(4'h8, 8'h44, 2'h3, 1'b0, 2'h0, 3'h0, 32'h100, 32'h0);
    check({31'h0, test_ok}, 32'h0);
    apb(1'b0, awf_pkg::ADDR_STAT, 32'h0);
    check(rd, {16'd15, 16'h20});
    flip <= 1'b1;
    row(4'h0, 8'h12, 2'h3, 1'b0, 2'h0, 3'h0, 32'h7, 32'h0);
    flip <= 1'b0;
    apb(1'b0, awf_pkg::ADDR_RX, 32'h0);
    check(rd, lastw ^ 32'h80000000);
    apb(1'b0, awf_pkg::ADDR_STAT, 32'h0);
    check({31'h0, rd[8]}, 32'h1);
    apb(1'b1, awf_pkg::ADDR_STAT, 32'h100);
    apb(1'b0, awf_pkg::ADDR_STAT, 32'h0);
    check({31'h0, rd[8]}, 32'h0);
    // fill the fifo with the far side stalled, then push once more
    stall <= 1'b1;
    c = mk(4'h0, 8'h11, 2'h3, 1'b0, 2'h0, 3'h0);
    for (int i = 0; i < 8; i++) push(c, i, 32'h0);
    apb(1'b0, awf_pkg::ADDR_STAT, 32'h0);
    check({26'h0, rd[5:0]}, 32'h18);
    fork
      push(c, 32'h8, 32'h0);
      begin
        repeat (20) @(posedge pclk);
        check({30'h0, pready, tx_valid}, 32'h1);
        stall <= 1'b0;
        slow  <= 1'b1;
      end
    join
    for (int i = 0; i < 9; i++) take(expw(c, i, 32'h0), 9 - i);
    apb(1'b0, awf_pkg::ADDR_STAT, 32'h0);
    check({26'h0, rd[5:0]}, 32'h20);
    check(n_bad, 32'h0);
    finish_test();
  end
endmodule // test_avionics_word_formatter
